/* dv/big_device_model.sv */
// Purpose: peripheral element on the acknowledge chain
// Assumes: bench pulses fire for one clk cycle
// Notes: released vector lines show the inverse of the last value
`timescale 1ns/1ps
module big_device_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench control
   input wire logic fire,
   input wire logic [1:0] levelIdx,
   input wire logic [big_pkg::VEC_W-1:0] vecValue,
   input wire logic [3:0] respDelay,
   // bus side
   input wire logic grantIn,
   output logic grantOut,
   output logic [big_pkg::NUM_LEVELS-1:0] request,
   output logic vectorValid,
   output logic [big_pkg::VEC_W-1:0] deviceVector
);
   import big_pkg::*;
   // ****************************************
   // request, chain and vector
   // ****************************************
   logic pending;
   logic [3:0] waitCnt;
   assign request = pending ? (4'h1 << levelIdx) : 4'h0;
   assign grantOut = grantIn & ~pending;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         waitCnt <= 4'h0;
         vectorValid <= 1'b0;
         deviceVector <= 9'h000;
      end else begin
         if (fire) begin
            pending <= 1'b1;
         end
         if (pending && grantIn && !vectorValid) begin
            if (waitCnt == respDelay) begin
               vectorValid <= 1'b1;
               deviceVector <= vecValue;
            end else begin
               waitCnt <= waitCnt + 4'h1;
            end
         end
         if (vectorValid && !grantIn) begin
            vectorValid <= 1'b0;
            pending <= 1'b0;
            waitCnt <= 4'h0;
            deviceVector <= ~deviceVector;
         end
      end
   end
endmodule : big_device_model

/* dv/bus_interrupt_grant_arbiter_bench.sv */
// Purpose: self-checking bench for the interrupt grant arbiter
// Assumes: inputs driven on the falling clock edge
// Notes: two chain devices, the higher level nearer the arbiter
`timescale 1ns/1ps
module bus_interrupt_grant_arbiter_bench;
   import big_pkg::*;
   // ****************************************
   // signals, rows and instances
   // ****************************************
   typedef struct packed {
      logic four;
      logic multi;
      logic [1:0] idx;
      logic [8:0] vec;
      logic [3:0] lines;
      logic [4:0] grantPri;
      logic [4:0] finalPri;
   } big_row_t;
   localparam logic [31:0] BASE = 32'h00001000;
   localparam logic [8:0] VEC_HI = 9'h1F4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic busFourGrant = 1'b0;
   logic multilevelDispatchSetting = 1'b0;
   logic setPriorityStrobe = 1'b0;
   logic [4:0] setPriorityValue = 5'h00;
   logic returnStrobe = 1'b0;
   logic [4:0] returnPriority = 5'h00;
   logic fireLo = 1'b0;
   logic fireHi = 1'b0;
   logic [1:0] loIdx = 2'h0;
   logic [8:0] vecLo = 9'h000;
   logic [3:0] busGrantLine, reqLo, reqHi;
   logic ack, hiPass, validLo, validHi, dispatchValid, fault, crash;
   logic [8:0] vecOutLo, vecOutHi;
   logic [4:0] pri, savedPri, devPri;
   logic [31:0] dispatchAddress;
   int errors = 0;
   int checks_done = 0;
   big_row_t rows [10] = '{'{1'b1, 1'b0, 2'h0, 9'h040, 4'h1, 5'h14, 5'h14},
      '{1'b1, 1'b0, 2'h1, 9'h085, 4'h2, 5'h15, 5'h15}, '{1'b1, 1'b0, 2'h2, 9'h0CA, 4'h4, 5'h16, 5'h16},
      '{1'b1, 1'b0, 2'h3, 9'h1FF, 4'h8, 5'h17, 5'h17}, '{1'b1, 1'b1, 2'h2, 9'h100, 4'h4, 5'h16, 5'h16},
      '{1'b0, 1'b0, 2'h0, 9'h004, 4'h0, 5'h17, 5'h17}, '{1'b0, 1'b0, 2'h3, 9'h1F8, 4'h0, 5'h17, 5'h17},
      '{1'b0, 1'b1, 2'h0, 9'h13C, 4'h0, 5'h17, 5'h14}, '{1'b0, 1'b1, 2'h1, 9'h0A0, 4'h0, 5'h17, 5'h15},
      '{1'b0, 1'b1, 2'h3, 9'h1FC, 4'h0, 5'h17, 5'h17}};
   always #20 clk = ~clk;
   big_arbiter u_big_arbiter (.clk(clk), .rst_n(rst_n), .busFourGrant(busFourGrant),
      .multilevelDispatchSetting(multilevelDispatchSetting), .fourGrantBusRequest(reqLo | reqHi),
      .busGrantLine(busGrantLine), .singleGrantBusRequest(reqLo | reqHi), .interruptAcknowledgeChain(ack),
      .vectorValid(validLo | validHi), .deviceVector(validHi ? vecOutHi : vecOutLo), .dispatchBase(BASE),
      .setPriorityStrobe(setPriorityStrobe), .setPriorityValue(setPriorityValue), .returnStrobe(returnStrobe),
      .returnPriority(returnPriority), .processorPriorityLevel(pri), .dispatchValid(dispatchValid),
      .dispatchAddress(dispatchAddress), .savedPriority(savedPri), .devicePriority(devPri),
      .illegalBusConfigCrash(crash), .reservedOperandFault(fault));
   // higher level device sits nearer the arbiter
   big_device_model u_dev_hi (.clk(clk), .rst_n(rst_n), .fire(fireHi), .levelIdx(2'h3), .vecValue(VEC_HI),
      .respDelay(4'h3), .grantIn(ack | busGrantLine[3]), .grantOut(hiPass), .request(reqHi),
      .vectorValid(validHi), .deviceVector(vecOutHi));
   big_device_model u_dev_lo (.clk(clk), .rst_n(rst_n), .fire(fireLo), .levelIdx(loIdx), .vecValue(vecLo),
      .respDelay(4'h0), .grantIn(hiPass | busGrantLine[loIdx]), .grantOut(), .request(reqLo),
      .vectorValid(validLo), .deviceVector(vecOutLo));
   task automatic wrap_up();
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic do_reset(input logic four, input logic ml);
      @(negedge clk);
      rst_n = 1'b0;
      busFourGrant = four;
      multilevelDispatchSetting = ml;
      repeat (8) @(negedge clk);
      check("reset pri", pri, PRI_RESET);
      check("reset grant", {ack, busGrantLine}, 5'h00);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask : do_reset
   task automatic set_pri(input logic [4:0] v);
      repeat (2) @(negedge clk);
      setPriorityStrobe = 1'b1;
      setPriorityValue = v;
      @(negedge clk);
      setPriorityStrobe = 1'b0;
      @(negedge clk);
   endtask : set_pri
   task automatic fire_dev(input logic lo, input logic hi);
      @(negedge clk);
      fireLo = lo;
      fireHi = hi;
      @(negedge clk);
      fireLo = 1'b0;
      fireHi = 1'b0;
   endtask : fire_dev
   task automatic wait_for(input int which);
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         if (which == 0 && (ack === 1'b1 || |busGrantLine === 1'b1)) return;
         if (which == 1 && dispatchValid === 1'b1) return;
      end
      errors++;
      $display("mismatch wait %0d expected 1 seen 0", which);
      wrap_up();
   endtask : wait_for
   task automatic serve(input logic [8:0] vec, input logic [3:0] lines, input logic [4:0] gp, input logic [4:0] fp,
      input logic [4:0] dp);
      wait_for(0);
      check("grant lines", busGrantLine, lines);
      check("ack", ack, lines == 4'h0);
      check("grant pri", pri, gp);
      check("saved pri", savedPri, 5'h10);
      check("device pri", devPri, dp);
      wait_for(1);
      check("address", dispatchAddress, (BASE + {vec[8:2], 2'h0}) & 32'hFFFFFFFC);
      check("final pri", pri, fp);
      check("crash", crash, 1'b0);
   endtask : serve
   task automatic ret(input logic [4:0] v, input logic expFault, input logic [4:0] expPri);
      logic f;
      @(negedge clk);
      returnStrobe = 1'b1;
      returnPriority = v;
      @(negedge clk);
      returnStrobe = 1'b0;
      f = fault;
      @(negedge clk);
      f = f | fault;
      check("fault", f, expFault);
      check("return pri", pri, expPri);
   endtask : ret
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      foreach (rows[r]) begin
         do_reset(rows[r].four, rows[r].multi);
         set_pri(5'h10);
         loIdx = rows[r].idx;
         vecLo = rows[r].vec;
         fire_dev(1'b1, 1'b0);
         serve(rows[r].vec, rows[r].lines, rows[r].grantPri, rows[r].finalPri, PRI_BASE + {3'h0, rows[r].idx});
      end
      do_reset(1'b1, 1'b0);
      set_pri(5'h15);
      loIdx = 2'h1;
      vecLo = 9'h08C;
      fire_dev(1'b1, 1'b0);
      repeat (10) @(negedge clk);
      check("equal level refused", busGrantLine, 4'h0);
      set_pri(5'h10);
      serve(9'h08C, 4'h2, 5'h15, 5'h15, 5'h15);
      do_reset(1'b0, 1'b0);
      multilevelDispatchSetting = 1'b1;
      set_pri(5'h10);
      loIdx = 2'h0;
      vecLo = 9'h104;
      fire_dev(1'b1, 1'b0);
      serve(9'h104, 4'h0, 5'h17, 5'h17, 5'h14);
      fire_dev(1'b0, 1'b1);
      repeat (10) @(negedge clk);
      check("top level blocked", ack, 1'b0);
      fire_dev(1'b1, 1'b0);
      set_pri(5'h10);
      serve(VEC_HI, 4'h0, 5'h17, 5'h17, 5'h17);
      set_pri(5'h10);
      serve(9'h104, 4'h0, 5'h17, 5'h17, 5'h14);
      set_pri(5'h10);
      ret(5'h12, 1'b1, 5'h10);
      ret(5'h0F, 1'b0, 5'h0F);
      wrap_up();
   end
endmodule : bus_interrupt_grant_arbiter_bench

/* rtl/big_arbiter.sv */
// Purpose: processor-side interrupt arbitration, grant and dispatch checks
// Assumes: requests and vector from peripherals are asynchronous pins
// Notes: priority held here; software steps are strobes from the core
`timescale 1ns/1ps
module big_arbiter
   import big_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus configuration straps
   input wire logic busFourGrant,
   input wire logic multilevelDispatchSetting,
   // four-grant bus
   input wire logic [big_pkg::NUM_LEVELS-1:0] fourGrantBusRequest,
   output logic [big_pkg::NUM_LEVELS-1:0] busGrantLine,
   // single-grant bus; vector inputs also serve the four-grant bus
   input wire logic [big_pkg::NUM_LEVELS-1:0] singleGrantBusRequest,
   output logic interruptAcknowledgeChain,
   input wire logic vectorValid,
   input wire logic [big_pkg::VEC_W-1:0] deviceVector,
   // core side
   input wire logic [big_pkg::ADDR_W-1:0] dispatchBase,
   input wire logic setPriorityStrobe,
   input wire logic [big_pkg::PRI_W-1:0] setPriorityValue,
   input wire logic returnStrobe,
   input wire logic [big_pkg::PRI_W-1:0] returnPriority,
   output logic [big_pkg::PRI_W-1:0] processorPriorityLevel,
   output logic dispatchValid,
   output logic [big_pkg::ADDR_W-1:0] dispatchAddress,
   output logic [big_pkg::PRI_W-1:0] savedPriority,
   output logic [big_pkg::PRI_W-1:0] devicePriority,
   output logic illegalBusConfigCrash,
   output logic reservedOperandFault
);
   import big_pkg::*;

   // ****************************************
   // input synchronisation
   // ****************************************
   logic [NUM_LEVELS-1:0] reqFourS;
   logic [NUM_LEVELS-1:0] reqSingleS;
   logic vecValidS;
   logic fourStrapS;
   logic mlStrapS;
   logic [VEC_W-1:0] vecS;
   logic vecValidPrev;

   big_sync #(.WIDTH(2*NUM_LEVELS)) u_req_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async({fourGrantBusRequest, singleGrantBusRequest}),
      .synced({reqFourS, reqSingleS})
   );
   big_sync #(.WIDTH(VEC_W+3)) u_mode_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async({deviceVector, vectorValid, multilevelDispatchSetting, busFourGrant}),
      .synced({vecS, vecValidS, mlStrapS, fourStrapS})
   );

   // ****************************************
   // strap capture at reset release
   // ****************************************
   logic strapTaken;
   logic [1:0] strapWait;
   logic [1:0] next_strapWait;
   logic multilevel;
   logic fourGrantMode;
   logic next_strapTaken;
   logic next_multilevel;
   logic next_fourGrantMode;

   always_comb begin
      // straps need two edges through the synchroniser before they are valid
      next_strapWait = {strapWait[0], 1'b1};
      next_strapTaken = strapTaken;
      next_multilevel = multilevel;
      next_fourGrantMode = fourGrantMode;
      if (!strapTaken && strapWait[1]) begin
         next_strapTaken = 1'b1;
         next_fourGrantMode = fourStrapS;
         // only meaningful on the single-grant bus
         next_multilevel = mlStrapS & ~fourStrapS;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapTaken <= 1'b0;
         strapWait <= 2'h0;
         multilevel <= 1'b0;
         fourGrantMode <= 1'b0;
      end else begin
         strapTaken <= next_strapTaken;
         strapWait <= next_strapWait;
         multilevel <= next_multilevel;
         fourGrantMode <= next_fourGrantMode;
      end
   end

   // ****************************************
   // arbitration
   // ****************************************
   logic [NUM_LEVELS-1:0] activeReq;
   logic winValid;
   logic [1:0] winIdx;

   always_comb begin
      activeReq = fourGrantMode ? reqFourS : reqSingleS;
      winValid = 1'b0;
      winIdx = IDX_W0;
      // highest eligible level wins
      for (int i = 0; i < NUM_LEVELS; i++) begin
         if (activeReq[i] && big_level_pri(2'(i)) > processorPriorityLevel) begin
            winValid = 1'b1;
            winIdx = 2'(i);
         end
      end
   end

   // ****************************************
   // grant and dispatch sequencer
   // ****************************************
   big_state_t state;
   big_state_t next_state;
   logic [NUM_LEVELS-1:0] next_busGrantLine;
   logic next_ack;
   logic [PRI_W-1:0] next_pri;
   logic next_dispValid;
   logic [ADDR_W-1:0] next_dispAddr;
   logic [PRI_W-1:0] next_saved;
   logic [PRI_W-1:0] next_devPri;
   logic next_crash;
   logic next_rof;
   logic [6:0] waitCnt;
   logic [6:0] next_waitCnt;
   logic [1:0] grantIdx;
   logic [1:0] next_grantIdx;

   always_comb begin
      next_state = state;
      next_busGrantLine = '0;
      next_ack = 1'b0;
      next_pri = processorPriorityLevel;
      next_dispValid = 1'b0;
      next_dispAddr = dispatchAddress;
      next_saved = savedPriority;
      next_devPri = devicePriority;
      next_crash = illegalBusConfigCrash;
      next_rof = 1'b0;
      next_waitCnt = waitCnt;
      next_grantIdx = grantIdx;
      case (state)
         BIG_IDLE: begin
            if (setPriorityStrobe) begin
               next_pri = setPriorityValue;
            end else if (returnStrobe) begin
               if (returnPriority > processorPriorityLevel) begin
                  next_rof = 1'b1;
               end else begin
                  next_pri = returnPriority;
               end
            end else if (winValid && strapTaken) begin
               next_saved = processorPriorityLevel;
               next_devPri = big_level_pri(winIdx);
               next_grantIdx = winIdx;
               next_waitCnt = '0;
               if (fourGrantMode) begin
                  next_busGrantLine[winIdx] = 1'b1;
                  next_pri = big_level_pri(winIdx);
               end else begin
                  next_ack = 1'b1;
                  next_pri = PRI_TOP;
               end
               next_state = BIG_ACK;
            end
         end
         BIG_ACK: begin
            next_busGrantLine = fourGrantMode ? (4'h1 << grantIdx) : 4'h0;
            next_ack = ~fourGrantMode;
            next_waitCnt = waitCnt + 7'h01;
            if (vecValidS && !vecValidPrev) begin
               next_busGrantLine = '0;
               next_ack = 1'b0;
               next_dispAddr = (dispatchBase + {23'h0, vecS[8:2], 2'h0}) & ADDR_ALIGN_MASK;
               next_state = BIG_DISPATCH;
            end else if (waitCnt == ACK_TIMEOUT) begin
               next_busGrantLine = '0;
               next_ack = 1'b0;
               next_pri = savedPriority;
               next_state = BIG_IDLE;
            end
         end
         BIG_DISPATCH: begin
            next_dispValid = 1'b1;
            next_state = BIG_IDLE;
            if (multilevel && !fourGrantMode) begin
               if (devicePriority <= savedPriority) begin
                  next_crash = 1'b1;
                  next_dispValid = 1'b0;
                  next_state = BIG_FAULT;
               end else begin
                  next_pri = devicePriority;
               end
            end
         end
         BIG_FAULT: begin
            next_state = BIG_FAULT;
         end
         default: begin
            next_state = BIG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= BIG_IDLE;
         busGrantLine <= '0;
         interruptAcknowledgeChain <= 1'b0;
         processorPriorityLevel <= PRI_RESET;
         dispatchValid <= 1'b0;
         dispatchAddress <= '0;
         savedPriority <= '0;
         devicePriority <= '0;
         illegalBusConfigCrash <= 1'b0;
         reservedOperandFault <= 1'b0;
         waitCnt <= '0;
         grantIdx <= IDX_W0;
         vecValidPrev <= 1'b0;
      end else begin
         state <= next_state;
         busGrantLine <= next_busGrantLine;
         interruptAcknowledgeChain <= next_ack;
         processorPriorityLevel <= next_pri;
         dispatchValid <= next_dispValid;
         dispatchAddress <= next_dispAddr;
         savedPriority <= next_saved;
         devicePriority <= next_devPri;
         illegalBusConfigCrash <= next_crash;
         reservedOperandFault <= next_rof;
         waitCnt <= next_waitCnt;
         grantIdx <= next_grantIdx;
         vecValidPrev <= vecValidS;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_single_grant_top: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(interruptAcknowledgeChain) |-> processorPriorityLevel == PRI_TOP)
      else $error("single-grant grant did not raise priority to top");
   a_four_grant_level: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(|busGrantLine) |-> processorPriorityLevel == devicePriority && $onehot(busGrantLine))
      else $error("four-grant priority does not match granted level");
   a_no_grant_below: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(|busGrantLine | interruptAcknowledgeChain) |-> devicePriority > savedPriority)
      else $error("granted request not above current priority");
   a_top_refuses_all: assert property (@(posedge clk) disable iff (!rst_n)
      (state == BIG_IDLE && processorPriorityLevel == PRI_TOP) |=> !$rose(interruptAcknowledgeChain))
      else $error("grant issued at top priority");
   a_grant_one_line: assert property (@(posedge clk) disable iff (!rst_n)
      !(interruptAcknowledgeChain && |busGrantLine))
      else $error("both grant styles active");
   a_dispatch_lower: assert property (@(posedge clk) disable iff (!rst_n)
      (dispatchValid && multilevel && !fourGrantMode) |-> processorPriorityLevel == devicePriority)
      else $error("multilevel dispatch did not lower priority");
   a_crash_cause: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(illegalBusConfigCrash) |-> multilevel && devicePriority <= savedPriority)
      else $error("crash without illegal placement");
   a_return_fault: assert property (@(posedge clk) disable iff (!rst_n)
      reservedOperandFault |-> $stable(processorPriorityLevel))
      else $error("faulting return changed priority");
   a_entry_aligned: assert property (@(posedge clk) disable iff (!rst_n)
      dispatchValid |-> dispatchAddress[1:0] == 2'h0)
      else $error("dispatch entry not word aligned");
   a_mode_static: assert property (@(posedge clk) disable iff (!rst_n)
      strapTaken && $past(strapTaken) |-> $stable(multilevel))
      else $error("multilevel mode changed after initialization");
endmodule : big_arbiter

/* rtl/big_pkg.sv */
// Purpose: constants and types for the bus interrupt grant arbiter
// Assumes: four request levels, five-bit processor priority
// Notes: no software-visible registers
package big_pkg;
   localparam int NUM_LEVELS = 4;
   localparam int PRI_W = 5;
   localparam int VEC_W = 9;
   localparam int TBL_ENTRIES = 128;
   localparam int TBL_IDX_W = 7;
   localparam int ADDR_W = 32;
   localparam logic [PRI_W-1:0] PRI_BASE = 5'h14;
   localparam logic [PRI_W-1:0] PRI_TOP = 5'h17;
   localparam logic [PRI_W-1:0] PRI_RESET = 5'h1F;
   localparam logic [2:0] LEVEL_LOW = 3'h4;
   localparam logic [1:0] IDX_W0 = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_ALIGN_MASK = 32'hFFFFFFFC;
   localparam int ACK_TIMEOUT_CYC = 64;
   localparam logic [6:0] ACK_TIMEOUT = 7'h40;

   typedef enum logic [2:0] {
      BIG_IDLE = 3'b000,
      BIG_ACK = 3'b001,
      BIG_DISPATCH = 3'b011,
      BIG_FAULT = 3'b010
   } big_state_t;

   function automatic logic [PRI_W-1:0] big_level_pri(input logic [1:0] idx);
      big_level_pri = PRI_BASE + {3'h0, idx};
   endfunction : big_level_pri
endpackage : big_pkg

/* rtl/big_sync.sv */
// Purpose: two-flop synchroniser for request and chain inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module big_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_synced;

   always_comb begin
      next_stage1 = async;
      next_synced = stage1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         synced <= '0;
      end else begin
         stage1 <= next_stage1;
         synced <= next_synced;
      end
   end
endmodule : big_sync
